// >>> inc/psv_map.svh
`ifndef PSV_MAP_SVH
`define PSV_MAP_SVH
// register word offsets (byte address = offset, used unscaled, so not all aligned to 4)
`define PSV_REG_PC_LOW_BYTE      8'h06
`define PSV_REG_TABLE_POINTER    8'h07
`define PSV_REG_TABLE_HIGH_LATCH 8'h08
`define PSV_REG_BANK_SELECT      8'h04
`define PSV_REG_IRQ_ENABLE       8'h40
`define PSV_REG_IRQ_PENDING      8'h41
`define PSV_REG_STACK_FREE       8'h42
`define PSV_REG_PC_HIGH          8'h43
// interrupt vectors
`define PSV_VEC_RESET  13'h0000
`define PSV_VEC_EXT0   13'h0004
`define PSV_VEC_EXT1   13'h0008
`define PSV_VEC_TMR0   13'h000c
`define PSV_VEC_TMR1   13'h0010
`define PSV_VEC_SERIAL 13'h0014
`define PSV_VEC_MULTI  13'h0018
// reset values
`define PSV_RST_PC     13'h0000
`define PSV_RST_BYTE   8'h00
`define PSV_RST_IRQEN  6'h00
// field positions
`define PSV_BANK_LSB   5
`define PSV_PAGE_LSB   8
// timing
`define PSV_PHASES     4
`define PSV_SERIAL_BITS 8
`endif

// >>> inc/psv_pkg.sv
package psv_pkg;
    // sequencer operation presented by the decoder for the executing word
    typedef enum logic [2:0] {
        PSV_OP_NONE,
        PSV_OP_SKIP,
        PSV_OP_JUMP,
        PSV_OP_CALL,
        PSV_OP_RETURN,
        PSV_OP_TABRD_CUR,
        PSV_OP_TABRD_LAST
    } psv_op_type;

    // decoded instruction request from the execute unit
    typedef struct packed {
        psv_op_type  op;
        logic        cond;
        logic [12:0] target;
        logic [7:0]  dest;
    } psv_exec_type;

    // table read result towards data memory
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } psv_dmem_wr_type;
endpackage

// >>> hw/psv_sequencer.sv
`timescale 1ns/10ps
`include "psv_map.svh"
module psv_sequencer
    import psv_pkg::*;
#(
    parameter int PC_WIDTH = 13,
    parameter int PHASES   = 4
) (
    input  wire logic                core_clk,
    input  wire logic                srst,
    // wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // program memory
    output logic      [13:0]         pmem_addr,
    input  wire logic [15:0]         pmem_data,
    // decoded instruction of the word in execution
    input  wire psv_exec_type        exec_req,
    output logic      [15:0]         exec_word,
    output logic                     exec_valid,
    output logic      [1:0]          phase,
    // stack
    input  wire logic                stack_full,
    input  wire logic [12:0]         stack_top,
    output logic                     stack_push,
    output logic                     stack_pop,
    output logic      [12:0]         stack_data,
    // interrupt sources
    input  wire logic                ext_irq0_n,
    input  wire logic                ext_irq1_n,
    input  wire logic                tmr0_ovf,
    input  wire logic                tmr1_ovf,
    input  wire logic                serial_bit_done,
    input  wire logic                rtc_tick,
    input  wire logic                remote_timer_input,
    input  wire logic                remote_timer_ovf,
    // table read result
    output psv_dmem_wr_type          dmem_wr
);

    // elaboration checks
    initial begin
        if (PC_WIDTH != 13) $error("psv_sequencer: PC_WIDTH must be 13");
        if (PHASES != `PSV_PHASES) $error("psv_sequencer: PHASES must be 4");
    end

    // interrupt source index: 0 ext0 .. 5 multi-function
    // index order is also the priority order, lowest first
    localparam int NSRC = 6;

    // thirteen-bit counter
    // the bank bit sits outside the pc, so a pc wrap never crosses banks
    logic [12:0]     pc;              // program counter
    logic [1:0]      ph;              // phase counter
    logic            dummy;           // current execute slot is a dummy
    logic            tab_pend;        // table read second cycle
    logic [13:0]     tab_addr;        // held table address
    logic [7:0]      tab_dest;        // held destination
    logic [7:0]      table_pointer;   // table pointer register
    logic [7:0]      table_high_latch;// high byte of last table read
    logic [7:0]      bank_select_pointer; // bank pointer register
    logic [5:0]      irq_en;          // per-source enables
    logic [5:0]      irq_pend;        // latched requests
    logic [3:0]      mf_en;           // multi-function source enables
    logic [2:0]      ser_cnt;         // serial bit counter
    logic            rmt_d;           // remote input history
    logic            ext0_d;          // ext0 history
    logic            ext1_d;          // ext1 history
    logic [15:0]     fetch_word;      // word fetched this cycle
    logic            cyc_end;         // last phase of instruction cycle
    logic            wb_hit;          // new bus request
    logic            wb_wr;           // write completing on the ack edge
    logic            pcl_wr;          // pc low byte write
    logic [5:0]      raw_ev;          // source events this cycle
    logic [5:0]      grant;           // one-hot chosen source
    logic            take_irq;        // vector at this cycle end

    // pick the lowest numbered pending source
    function automatic logic [5:0] psv_pick(input logic [5:0] req);
        logic [5:0] g;
        g = 6'h00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                g = 6'h00;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    // vector address for a one-hot grant
    // vectors sit four words apart from the first source upward
    function automatic logic [12:0] psv_vec(input logic [5:0] g);
        logic [12:0] v;
        v = `PSV_VEC_RESET;
        unique case (1'b1)
            g[0]: v = `PSV_VEC_EXT0;
            g[1]: v = `PSV_VEC_EXT1;
            g[2]: v = `PSV_VEC_TMR0;
            g[3]: v = `PSV_VEC_TMR1;
            g[4]: v = `PSV_VEC_SERIAL;
            g[5]: v = `PSV_VEC_MULTI;
            default: v = `PSV_VEC_RESET;
        endcase
        return v;
    endfunction

    // bus decode: a request is taken once, ack follows one clock later
    assign cyc_end = (ph == 2'(PHASES - 1));
    assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land on the edge where the master sees ack; the request
    // still stands there, so address and data are stable
    assign wb_wr   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign pcl_wr  = wb_wr && (wb_adr_i == `PSV_REG_PC_LOW_BYTE);
    // program memory answers combinationally, taken at the phase-3 edge
    assign fetch_word = pmem_data;

    // phase counter, one clock each
    // free running: no instruction ever stretches its cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ph <= 2'h0;
        end else begin
            ph <= ph + 2'h1;
        end
    end

    // event detection for sources
    // ext pins idle high, so their history resets high and reset makes no edge
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rmt_d   <= 1'b0;
            ext0_d  <= 1'b1;
            ext1_d  <= 1'b1;
            ser_cnt <= 3'h0;
        end else begin
            rmt_d  <= remote_timer_input;
            ext0_d <= ext_irq0_n;
            ext1_d <= ext_irq1_n;
            // count serial bits to eight
            // three bits wrap after the eighth pulse, no clear needed
            if (serial_bit_done) begin
                ser_cnt <= ser_cnt + 3'h1;
            end
        end
    end

    always_comb begin
        raw_ev[0] = ext0_d && !ext_irq0_n;   // falling edge, active low
        raw_ev[1] = ext1_d && !ext_irq1_n;
        raw_ev[2] = tmr0_ovf;
        raw_ev[3] = tmr1_ovf;
        raw_ev[4] = serial_bit_done && (ser_cnt == 3'(`PSV_SERIAL_BITS - 1));
        // each multi source gated by own enable
        // remote edges use the one-clock history of the pin
        raw_ev[5] = (rtc_tick && mf_en[0])
                  || (!rmt_d && remote_timer_input && mf_en[1])
                  || (rmt_d && !remote_timer_input && mf_en[2])
                  || (remote_timer_ovf && mf_en[3]);
    end

    assign grant = psv_pick(irq_pend & irq_en);
    // full stack defers the grant
    // only a slot whose word leaves the pc alone may be cut: that word
    // completes, the fetched next word is dropped and its address is
    // pushed, so nothing is lost on return
    assign take_irq = cyc_end && (grant != 6'h00) && !stack_full && !dummy
                      && !tab_pend && !pcl_wr && (exec_req.op == PSV_OP_NONE);

    // pending flags: set wins over the acknowledge
    // a source firing in its grant cycle stays pending, so no event is lost
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_pend <= 6'h00;
        end else begin
            irq_pend <= (irq_pend & ~(take_irq ? grant : 6'h00)) | raw_ev;
        end
    end

    // program counter, pipeline and table sequencing
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pc         <= `PSV_RST_PC;
            dummy      <= 1'b1;
            tab_pend   <= 1'b0;
            tab_addr   <= 14'h0000;
            tab_dest   <= `PSV_RST_BYTE;
            exec_word  <= 16'h0000;
            exec_valid <= 1'b0;
            table_high_latch <= `PSV_RST_BYTE;
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            stack_data <= `PSV_RST_PC;
            dmem_wr    <= '0;
        end else begin
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            dmem_wr    <= '0;
            if (cyc_end) begin
                exec_word  <= fetch_word;
                exec_valid <= 1'b1;
                pc    <= pc + 13'h1;
                dummy <= 1'b0;
                if (tab_pend) begin
                    // low byte out, high byte latched
                    dmem_wr.valid    <= 1'b1;
                    dmem_wr.addr     <= tab_dest;
                    dmem_wr.data     <= fetch_word[7:0];
                    table_high_latch <= fetch_word[15:8];
                    tab_pend   <= 1'b0;
                    // the word after the table read was fetched before the
                    // table access took the bus; it is held and now runs
                    exec_word  <= exec_word;
                    exec_valid <= 1'b1;
                    // pc already points past that word
                    pc         <= pc;
                end else if (take_irq) begin
                    // vector with return address pushed
                    // the executing word finished; the fetched one re-runs later
                    stack_push <= 1'b1;
                    stack_data <= pc;
                    pc         <= psv_vec(grant);
                    dummy      <= 1'b1;
                    exec_valid <= 1'b0;
                end else if (pcl_wr && !dummy) begin
                    pc         <= {pc[12:8], wb_dat_i[7:0]};
                    dummy      <= 1'b1;
                    exec_valid <= 1'b0;
                end else if (!dummy) begin
                    unique case (exec_req.op)
                        PSV_OP_SKIP: begin
                            if (exec_req.cond) begin
                                dummy      <= 1'b1;
                                exec_valid <= 1'b0;
                            end
                        end
                        PSV_OP_JUMP: begin
                            pc         <= exec_req.target;
                            dummy      <= 1'b1;
                            exec_valid <= 1'b0;
                        end
                        PSV_OP_CALL: begin
                            stack_push <= 1'b1;
                            stack_data <= pc;
                            pc         <= exec_req.target;
                            dummy      <= 1'b1;
                            exec_valid <= 1'b0;
                        end
                        PSV_OP_RETURN: begin
                            stack_pop  <= 1'b1;
                            pc         <= stack_top;
                            dummy      <= 1'b1;
                            exec_valid <= 1'b0;
                        end
                        PSV_OP_TABRD_CUR, PSV_OP_TABRD_LAST: begin
                            tab_addr <= {bank_select_pointer[`PSV_BANK_LSB],
                                (exec_req.op == PSV_OP_TABRD_LAST) ? 5'h1f
                                : pc[12:`PSV_PAGE_LSB], table_pointer};
                            tab_dest <= exec_req.dest;
                            tab_pend <= 1'b1;
                            // table access slot runs nothing; the next word
                            // waits in exec_word and the pc advances as usual
                            exec_valid <= 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // bank bit above the 13-bit address
    // a table read borrows the program bus for one whole instruction cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pmem_addr <= 14'h0000;
            phase     <= 2'h0;
        end else begin
            pmem_addr <= tab_pend ? tab_addr
                         : {bank_select_pointer[`PSV_BANK_LSB], pc};
            phase     <= ph;
        end
    end

    // software registers and bus answer
    // read data is registered with ack and stands only in the ack cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h0000_0000;
            table_pointer       <= `PSV_RST_BYTE;
            bank_select_pointer <= `PSV_RST_BYTE;
            irq_en              <= `PSV_RST_IRQEN;
            mf_en               <= 4'h0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            // writes land where the master samples ack high
            if (wb_wr) begin
                unique case (wb_adr_i)
                    `PSV_REG_TABLE_POINTER: table_pointer <= wb_dat_i[7:0];
                    `PSV_REG_BANK_SELECT: bank_select_pointer <= wb_dat_i[7:0];
                    `PSV_REG_IRQ_ENABLE: begin
                        irq_en <= wb_dat_i[5:0];
                        mf_en  <= wb_dat_i[11:8];
                    end
                    default: begin
                    end
                endcase
            end
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i)
                    `PSV_REG_PC_LOW_BYTE:      wb_dat_o <= {24'h0, pc[7:0]};
                    `PSV_REG_TABLE_POINTER:    wb_dat_o <= {24'h0, table_pointer};
                    `PSV_REG_TABLE_HIGH_LATCH: wb_dat_o <= {24'h0, table_high_latch};
                    `PSV_REG_BANK_SELECT:      wb_dat_o <= {24'h0, bank_select_pointer};
                    `PSV_REG_IRQ_ENABLE:
                        wb_dat_o <= {20'h0, mf_en, 2'h0, irq_en};
                    `PSV_REG_IRQ_PENDING:      wb_dat_o <= {26'h0, irq_pend};
                    `PSV_REG_STACK_FREE:       wb_dat_o <= {31'h0, !stack_full};
                    `PSV_REG_PC_HIGH:          wb_dat_o <= {27'h0, pc[12:8]};
                    default:                   wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// >>> verif/psv_sequencer_asserts.sv
`timescale 1ns/10ps
// port-level checker for the sequencer
module psv_sequencer_chk
    import psv_pkg::*;
(
    input wire logic            core_clk,
    input wire logic            srst,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_ack_o,
    input wire logic [1:0]      phase,
    input wire psv_exec_type    exec_req,
    input wire logic            exec_valid,
    input wire logic            stack_push,
    input wire logic            stack_pop,
    input wire psv_dmem_wr_type dmem_wr
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // op of a live slot; a dummy slot decodes to nothing
    psv_op_type op_now;
    assign op_now = exec_valid ? exec_req.op : PSV_OP_NONE;
    chk_phase_step: assert property (
        $changed(phase) |-> phase == $past(phase) + 2'h1) else $error("phase skipped");
    chk_phase_period: assert property (
        $rose(phase == 2'h1) |-> ##3 phase == 2'h0 ##1 phase == 2'h1) else $error("bad period");
    chk_ack_take: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    chk_ack_stray: assert property (
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
    chk_jump_dummy: assert property (
        op_now inside {PSV_OP_JUMP, PSV_OP_CALL, PSV_OP_RETURN} |-> ##[1:8] !exec_valid)
        else $error("no dummy slot");
    chk_skip_dummy: assert property (
        op_now == PSV_OP_SKIP && exec_req.cond |-> ##[1:8] !exec_valid) else $error("skip kept");
    chk_call_push: assert property (
        op_now == PSV_OP_CALL |-> ##[1:8] stack_push) else $error("call no push");
    chk_ret_pop: assert property (
        op_now == PSV_OP_RETURN |-> ##[1:8] stack_pop) else $error("return no pop");
    chk_push_pulse: assert property (stack_push |=> !stack_push) else $error("push held");
    chk_table_write: assert property (
        op_now inside {PSV_OP_TABRD_CUR, PSV_OP_TABRD_LAST} |-> ##[1:12] dmem_wr.valid)
        else $error("no table write");
    chk_dmem_pulse: assert property (dmem_wr.valid |=> !dmem_wr.valid) else $error("wr held");
    chk_table_resume: assert property (
        dmem_wr.valid |-> exec_valid) else $error("table read overran");
    // main scenarios reached
    cov_push: cover property (stack_push);
    cov_pop: cover property (stack_pop);
    cov_table: cover property (dmem_wr.valid);
endmodule

bind psv_sequencer psv_sequencer_chk u_chk (.core_clk(core_clk), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .phase(phase),
    .exec_req(exec_req), .exec_valid(exec_valid), .stack_push(stack_push),
    .stack_pop(stack_pop), .dmem_wr(dmem_wr));

// >>> verif/psv_prog_model.sv
`timescale 1ns/10ps
// program memory plus a one-entry decoder
module psv_prog_model
    import psv_pkg::*;
(
    input  wire logic [13:0]  pmem_addr,
    output logic      [15:0]  pmem_data,
    input  wire logic [15:0]  exec_word,
    input  wire logic         exec_valid,
    input  wire logic [12:0]  plant_addr,
    input  wire psv_exec_type plant_op,
    output psv_exec_type      exec_req
);
    // each word holds its own address, so the bench sees where it runs
    assign pmem_data = {2'b10, pmem_addr};
    // only the planted word decodes to an op; dummy slots decode to none
    assign exec_req = (exec_valid && exec_word[12:0] == plant_addr) ? plant_op : '0;
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
`include "psv_map.svh"
module tb
    import psv_pkg::*;
;
    logic core_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, exec_valid, stack_full;
    logic stack_push, stack_pop, ext_irq0_n, ext_irq1_n, tmr0_ovf, tmr1_ovf;
    logic serial_bit_done, rtc_tick, remote_timer_input, remote_timer_ovf;
    logic [7:0]      wb_adr_i, rd;
    logic [31:0]     wb_dat_i, wb_dat_o;
    logic [13:0]     pmem_addr;
    logic [15:0]     pmem_data, exec_word, n, dn, found;
    logic [12:0]     stack_top, stack_data, plant_addr, pushed, site;
    logic [1:0]      phase;
    psv_exec_type    exec_req, plant_op;
    psv_dmem_wr_type dmem_wr, dm;
    int              error_cnt, samples_checked, cyc_cnt;

    psv_sequencer dut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pmem_addr(pmem_addr), .pmem_data(pmem_data), .exec_req(exec_req),
        .exec_word(exec_word), .exec_valid(exec_valid), .phase(phase),
        .stack_full(stack_full), .stack_top(stack_top), .stack_push(stack_push),
        .stack_pop(stack_pop), .stack_data(stack_data), .ext_irq0_n(ext_irq0_n),
        .ext_irq1_n(ext_irq1_n), .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf),
        .serial_bit_done(serial_bit_done), .rtc_tick(rtc_tick),
        .remote_timer_input(remote_timer_input), .remote_timer_ovf(remote_timer_ovf),
        .dmem_wr(dmem_wr));
    psv_prog_model prog (.pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .exec_word(exec_word), .exec_valid(exec_valid), .plant_addr(plant_addr),
        .plant_op(plant_op), .exec_req(exec_req));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // capture pulses, cut a hang short
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (stack_push === 1'b1)
            pushed <= stack_data;
        if (dmem_wr.valid === 1'b1)
            dm <= dmem_wr;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL t=%0t seen %h want %h", $time, s, e);
        end
    endtask
    // one classic wishbone cycle; waits for ack, however long
    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // wait for word a to execute; n cycles waited, dn of them dummy
    task automatic wx(input logic [12:0] a, input int lim);
        found = 16'h0;
        n = 16'h0;
        dn = 16'h0;
        while (found == 16'h0 && n < lim) begin
            @(posedge core_clk);
            n++;
            if (exec_valid !== 1'b1)
                dn++;
            if (exec_valid === 1'b1 && exec_word[12:0] === a)
                found = 16'h1;
        end
    endtask
    // place one op a little ahead of the running word, wait till it runs
    task automatic plant(input psv_op_type o, input logic c, input logic [12:0] t,
                         input logic [7:0] d);
        site = exec_word[12:0] + 13'h4;
        plant_addr <= site;
        plant_op <= '{o, c, t, d};
        wx(site, 40);
    endtask
    // park far from the vectors so a walk never fakes a vector
    task automatic away();
        plant(PSV_OP_JUMP, 1'b0, 13'h0800, 8'h00);
        wx(13'h0800, 20);
        plant_addr <= 13'h1fff;
    endtask
    task automatic fire(input int i);
        @(posedge core_clk);
        case (i)
            0: ext_irq0_n <= 1'b0;
            1: ext_irq1_n <= 1'b0;
            2: tmr0_ovf <= 1'b1;
            3: tmr1_ovf <= 1'b1;
            4: serial_bit_done <= 1'b1;
            5: rtc_tick <= 1'b1;
            6: remote_timer_input <= 1'b1;
            7: remote_timer_input <= 1'b0;
            8: remote_timer_ovf <= 1'b1;
            default: {tmr0_ovf, tmr1_ovf} <= 2'b11;
        endcase
        @(posedge core_clk);
        {ext_irq0_n, ext_irq1_n} <= 2'b11;
        {tmr0_ovf, tmr1_ovf, serial_bit_done, rtc_tick, remote_timer_ovf} <= 5'h00;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {srst, ext_irq0_n, ext_irq1_n} = 3'b111;
        {wb_cyc_i, wb_stb_i, wb_we_i, stack_full, tmr0_ovf, tmr1_ovf} = 6'h00;
        {serial_bit_done, rtc_tick, remote_timer_input, remote_timer_ovf} = 4'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        stack_top = 13'h0;
        plant_addr = 13'h1fff;
        plant_op = '0;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        wx(13'h0000, 20);
        check(found, 16'h1);
        wx(13'h0001, 20);
        check(n, 16'h4);
        check(dn, 16'h0);
        $display("done reset");
        plant(PSV_OP_JUMP, 1'b0, 13'h1a40, 8'h00);
        wx(13'h1a40, 20);
        check(dn, 16'h4);
        wx(13'h1a41, 20);
        check(n, 16'h4);
        for (int k = 0; k < 2; k++) begin
            plant(PSV_OP_SKIP, k == 0, 13'h0000, 8'h00);
            wx(site + 13'(2 - k), 20);
            check(dn, k == 0 ? 16'h4 : 16'h0);
        end
        $display("done jump and skip");
        found = 16'h0;
        for (int k = 0; k < 6 && found == 16'h0; k++) begin
            wb(`PSV_REG_PC_LOW_BYTE, 1'b1, 16'h0010);
            wx(13'h1a10, 12);
        end
        check(found, 16'h1);
        $display("done short jump");
        for (int k = 1; k >= 0; k--) begin
            wb(`PSV_REG_BANK_SELECT, 1'b1, k ? 16'h003f : 16'h001f);
            for (n = 0; n < 16 && pmem_addr[13] !== k[0]; n++) @(posedge core_clk);
            check({15'h0, pmem_addr[13]}, 16'(k));
        end
        wb(`PSV_REG_TABLE_POINTER, 1'b1, 16'h005a);
        for (int k = 0; k < 2; k++) begin
            plant(k ? PSV_OP_TABRD_LAST : PSV_OP_TABRD_CUR, 1'b0, 13'h0, 8'h44 + 8'(k));
            wx(site + 13'h2, 20);
            check({dm.addr, dm.data}, {8'h44 + 8'(k), 8'h5a});
            check(n, 16'h000c);
            wb(`PSV_REG_TABLE_HIGH_LATCH, 1'b1, 16'h0000);
            wb(`PSV_REG_TABLE_HIGH_LATCH, 1'b0, 16'h0000);
            check({8'h00, rd}, {11'h4, k ? 5'h1f : site[12:8]});
        end
        $display("done bank and table");
        plant(PSV_OP_CALL, 1'b0, 13'h0300, 8'h00);
        stack_top <= site + 13'h1;
        wx(13'h0300, 20);
        check({3'h0, pushed}, {3'h0, stack_top});
        check(dn, 16'h4);
        plant(PSV_OP_RETURN, 1'b0, 13'h0000, 8'h00);
        wx(stack_top, 20);
        check(dn, 16'h4);
        $display("done call and return");
        away();
        wb(`PSV_REG_IRQ_ENABLE, 1'b1, 16'h0000);
        fire(2);
        wx(13'h000c, 40);
        check(found, 16'h0);
        wb(`PSV_REG_IRQ_PENDING, 1'b0, 16'h0000);
        check({8'h00, rd}, 16'h0004);
        stack_full <= 1'b1;
        wb(`PSV_REG_IRQ_ENABLE, 1'b1, 16'h0008);
        fire(3);
        wx(13'h0010, 40);
        check(found, 16'h0);
        wb(`PSV_REG_IRQ_PENDING, 1'b0, 16'h0000);
        check({8'h00, rd}, 16'h000c);
        wb(`PSV_REG_STACK_FREE, 1'b0, 16'h0000);
        check({8'h00, rd}, 16'h0000);
        stack_full <= 1'b0;
        wx(13'h0010, 40);
        check(found, 16'h1);
        for (int i = 0; i < 9; i++) begin
            away();
            wb(`PSV_REG_IRQ_ENABLE, 1'b1,
               i < 5 ? 16'h0001 << i : 16'h0020 | (16'h0100 << (i - 5)));
            if (i == 4) begin
                repeat (7) fire(4);
                wx(13'h0014, 24);
                check(found, 16'h0);
            end
            fire(i);
            wx(13'(4 * (i < 5 ? i + 1 : 6)), 40);
            check(found, 16'h1);
        end
        away();
        wb(`PSV_REG_IRQ_ENABLE, 1'b1, 16'h000c);
        fire(9);
        wx(13'h000c, 40);
        check(found, 16'h1);
        wx(13'h0010, 40);
        check({15'h0, dn != 16'h0}, 16'h1);
        check({3'h0, pushed}, 16'h000d);
        $display("done interrupts");
        wrap_up();
    end
endmodule
